// ### hrmg_top.sv
// Host register map with byte lane ordering, word alias and indexed I/O port window
//
// Contract
// - Registers sixteen bits; width pin picks word/byte.
// - Default byte order: low even, high odd.
// - Reverse pin low swaps even and odd lanes.
// - Six-bit address decode, words at even offsets.
// - Byte mode unused byte zero; source id pair.
// - Alias enable maps spare byte to register four.
// - Four-bit window index reaches the I/O registers.
// - Index 1011: direction bits, zero means output.
// - Index 1010: write drives pins, read pin state.
// - Only hardware reset loads all initial values.
//
// Straps and pins pass
// two flip-flops first.
// Reads answer a cycle
// after the strobe.
`timescale 1ns/1ps
module hrmg_top #(
   parameter int IO_WIDTH = hrmg_pkg::IO_W
) (
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic                clkEn,
   // Soft reset
   input  wire logic                softReset,
   // Board straps
   input  wire logic                busWidthSelect,
   input  wire logic                byteLaneReverseN,
   // Host bus
   input  wire logic [5:0]          hostAddr,
   input  wire logic [15:0]         hostWrData,
   input  wire logic                hostWrEn,
   input  wire logic                hostRdEn,
   output logic      [15:0]         hostRdData,
   output logic                     hostRdValid,
   // Pin side
   input  wire logic [IO_WIDTH-1:0] ioPinsIn,
   output logic      [IO_WIDTH-1:0] ioPinsOut,
   output logic      [IO_WIDTH-1:0] ioPinsOe
);

   // Word index of each register slot, taken from the byte offsets
   // Index is offset / 2;
   // bit 0 only picks a lane.
   localparam logic [4:0] IDX_STATUS_MASK  = hrmg_pkg::OFF_LEGACY_STATUS_MASK[5:1];
   localparam logic [4:0] IDX_DIAG_COMMAND = hrmg_pkg::OFF_LEGACY_DIAG_COMMAND[5:1];
   localparam logic [4:0] IDX_REG_FOUR     = hrmg_pkg::OFF_LEGACY_REG_FOUR[5:1];
   localparam logic [4:0] IDX_REG_FIVE     = hrmg_pkg::OFF_LEGACY_REG_FIVE[5:1];
   localparam logic [4:0] IDX_WINDOW       = hrmg_pkg::OFF_INDEXED_WINDOW[5:1];
   localparam logic [4:0] IDX_IRQ_STATUS   = hrmg_pkg::OFF_EXT_IRQ_STATUS[5:1];
   localparam logic [4:0] IDX_IRQ_MASK     = hrmg_pkg::OFF_EXT_IRQ_MASK[5:1];
   localparam logic [4:0] IDX_EXT_COMMAND  = hrmg_pkg::OFF_EXT_COMMAND[5:1];
   localparam logic [4:0] IDX_TX_SOURCE    = hrmg_pkg::OFF_TX_SOURCE_ID[5:1];
   localparam logic [4:0] IDX_RX_FLAGS_HI  = hrmg_pkg::OFF_RX_FLAGS_HIGH[5:1];
   localparam logic [4:0] IDX_RX_FLAGS_LO  = hrmg_pkg::OFF_RX_FLAGS_LOW[5:1];
   localparam logic [4:0] IDX_MASTER_ID    = hrmg_pkg::OFF_TIME_MASTER_ID[5:1];
   localparam logic [4:0] IDX_MODE         = hrmg_pkg::OFF_OPERATING_MODE[5:1];
   localparam logic [4:0] IDX_HIGHEST_ID   = hrmg_pkg::OFF_HIGHEST_NODE_ID[5:1];
   localparam logic [4:0] IDX_OWN_ID       = hrmg_pkg::OFF_OWN_NODE_ID[5:1];
   localparam logic [4:0] IDX_PACKET_SIZE  = hrmg_pkg::OFF_PACKET_SIZE_CFG[5:1];
   localparam logic [4:0] IDX_PRESCALE     = hrmg_pkg::OFF_CLOCK_PRESCALE[5:1];
   localparam logic [4:0] IDX_PIN_INFO     = hrmg_pkg::OFF_PIN_STATE_INFO[5:1];
   localparam logic [4:0] IDX_UNUSED_A     = hrmg_pkg::OFF_UNUSED_SLOT_A[5:1];
   localparam logic [4:0] IDX_UNUSED_B     = hrmg_pkg::OFF_UNUSED_SLOT_B[5:1];
   localparam logic [4:0] IDX_ERROR_INFO   = hrmg_pkg::OFF_ERROR_INFO[5:1];
   localparam logic [4:0] IDX_RESERVED_A   = hrmg_pkg::OFF_RESERVED_SLOT_A[5:1];
   localparam logic [4:0] IDX_RESERVED_B   = hrmg_pkg::OFF_RESERVED_SLOT_B[5:1];

   // Other slots: plain
   // storage.

   // Reset image of the whole state word
   localparam hrmg_pkg::hrmg_state_s RST_STATE = '{
      words       : {32{hrmg_pkg::RST_WORD}},
      window      : {16{hrmg_pkg::RST_WINDOW_ENTRY}},
      ioDirection : hrmg_pkg::RST_IO_DIRECTION,
      ioValue     : hrmg_pkg::RST_IO_VALUE,
      rdData      : 16'h0000,
      rdValid     : 1'b0
   };

   // Direction resets to all
   // ones: every pin starts
   // as an input.

   // One packed state word
   // holds the whole map.
   hrmg_pkg::hrmg_state_s st_r;     // Registered state
   hrmg_pkg::hrmg_state_s st_nxt;   // Next state

   logic                wordModeSync;  // Settled bus width pin
   logic                laneRevNSync;  // Settled byte lane reverse pin, active low
   logic [IO_WIDTH-1:0] ioPinsSync;    // Settled I/O pin levels
   logic [1:0]          strapSync;     // Both straps after the synchroniser

   // Bit 0 width, bit 1
   // lane reverse.

   // Straps are board pins, so they cross into the clock domain first
   // Reset clears both stages,
   // so the block wakes in byte
   // mode with lanes reversed.
   hrmg_sync2 #(
      .WIDTH   (2)
   ) u_strap_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .asyncIn ({byteLaneReverseN, busWidthSelect}),
      .syncOut (strapSync)
   );

   assign wordModeSync = strapSync[0];
   assign laneRevNSync = strapSync[1];

   // Logic reads only
   // settled copies.

   // I/O pins are read through the same kind of synchroniser
   // A pin change reaches
   // read data two enabled
   // edges later.
   hrmg_sync2 #(
      .WIDTH   (IO_WIDTH)
   ) u_io_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .asyncIn (ioPinsIn),
      .syncOut (ioPinsSync)
   );

   // Slots with no register behind them
   // Reads give zero; writes
   // are dropped.
   function automatic logic isVacant(input logic [4:0] idx);
      isVacant = (idx == IDX_UNUSED_A) || (idx == IDX_UNUSED_B) ||
                 (idx == IDX_RESERVED_A) || (idx == IDX_RESERVED_B);
   endfunction

   // Registers that carry only a low byte; the legacy block is all byte wide
   // Upper byte reads zero;
   // writes to it are lost.
   function automatic logic isByteWide(input logic [4:0] idx);
      isByteWide = (idx <= IDX_WINDOW) || (idx == IDX_EXT_COMMAND) ||
                   (idx == IDX_TX_SOURCE) || (idx == IDX_MASTER_ID) ||
                   (idx == IDX_HIGHEST_ID) || (idx == IDX_OWN_ID) ||
                   (idx == IDX_PACKET_SIZE) || (idx == IDX_PRESCALE);
   endfunction

   logic [4:0]  wordIdx;      // Word slot addressed by the host
   logic        swapActive;   // Lane reversal in force
   logic        laneHigh;     // Byte access lands on bits 15 to 8
   logic [3:0]  windowIndex;  // Window selection from legacy register five
   logic        aliasEnable;  // Spare byte beside register four is a copy
   logic        aliasHit;     // Current byte access hits the copy
   logic [15:0] curWord;      // Present value of the addressed slot
   logic [15:0] mergedWord;   // Word after a write has been folded in
   logic [15:0] byteRead;     // Byte lane answer placed in the low bits

   // Pure decode of st_r and
   // the inputs, no state.

   // Word access ignores bit 0;
   // byte access uses it to
   // pick a lane.
   // Address and lane decode shared by reads and writes
   always_comb begin
      wordIdx     = hostAddr[5:1];
      swapActive  = ~laneRevNSync;
      // Even address is the low byte unless the lanes are reversed
      laneHigh    = ~wordModeSync & (hostAddr[0] ^ swapActive);
      windowIndex = st_r.words[IDX_REG_FIVE][hrmg_pkg::WIN_IDX_LSB +: hrmg_pkg::WIN_IDX_W];
      aliasEnable = st_r.words[IDX_MODE][hrmg_pkg::WIDE_ALIAS_BIT];
      aliasHit    = aliasEnable & laneHigh & (wordIdx == IDX_REG_FOUR);
   end

   // Shared by reads and
   // writes; a same-cycle
   // read sees old data.
   // Present value of the addressed slot as the host would see a word read
   always_comb begin
      curWord = 16'h0000;
      if (isVacant(wordIdx)) begin
         // Vacant slots hold nothing
         curWord = 16'h0000;
      end else if (wordIdx == IDX_WINDOW) begin
         // The window shows whichever entry the index selects
         // Other indices are plain
         // eight-bit storage.
         if (windowIndex == hrmg_pkg::WIN_IO_DIRECTION) begin
            curWord = {8'h00, st_r.ioDirection};
         end else if (windowIndex == hrmg_pkg::WIN_IO_VALUE) begin
            // Live pin levels, not the driven value, so inputs are visible
            curWord = {8'h00, ioPinsSync};
         end else begin
            curWord = {8'h00, st_r.window[windowIndex]};
         end
      end else if (wordIdx == IDX_PIN_INFO) begin
         // Read-only view of the straps as the block sees them
         // Settled straps, two
         // edges behind the pins.
         curWord = 16'h0000;
         curWord[hrmg_pkg::PIN_BUS_WIDTH_BIT]    = wordModeSync;
         curWord[hrmg_pkg::PIN_LANE_REVERSE_BIT] = laneRevNSync;
      end else if (isByteWide(wordIdx)) begin
         // Upper byte of a byte wide register is always zero
         curWord = {8'h00, st_r.words[wordIdx][7:0]};
      end else begin
         // Full word, including the receive source pair
         curWord = st_r.words[wordIdx];
      end
   end

   // Byte lane answer; the copy of register four shows its low byte
   // The lane moves down to
   // bits 7..0; bits 15..8
   // stay zero.
   always_comb begin
      byteRead = 16'h0000;
      if (aliasHit) begin
         byteRead = {8'h00, curWord[7:0]};
      end else if (laneHigh) begin
         byteRead = {8'h00, curWord[15:8]};
      end else begin
         // Low lane
         byteRead = {8'h00, curWord[7:0]};
      end
   end

   // Fold the host write data into the addressed word
   // In byte mode only the addressed
   // lane changes; the other holds.
   always_comb begin
      mergedWord = curWord;
      if (wordModeSync) begin
         // Word access replaces all sixteen bits
         mergedWord = hostWrData;
      end else if (aliasHit) begin
         // A write through the copy lands in the real low byte
         mergedWord = {curWord[15:8], hostWrData[7:0]};
      end else if (laneHigh) begin
         // High lane
         mergedWord = {hostWrData[7:0], curWord[7:0]};
      end else begin
         mergedWord = {curWord[15:8], hostWrData[7:0]};
      end
   end

   // Next state: host writes, read capture and software reset exceptions
   // Later steps win: read,
   // then write, then soft
   // reset.
   always_comb begin
      st_nxt         = st_r;
      st_nxt.rdValid = 1'b0;

      // A host read is answered one cycle later from a flip-flop
      // Stands until the
      // next read.
      if (hostRdEn) begin
         st_nxt.rdValid = 1'b1;
         if (wordModeSync) begin
            st_nxt.rdData = curWord;
         end else begin
            st_nxt.rdData = byteRead;
         end
      end

      // Host write, decoded by slot
      // One lane in
      // byte mode.
      if (hostWrEn) begin
         if (isVacant(wordIdx)) begin
            // Writes to vacant slots are dropped
            st_nxt = st_nxt;
         end else if (wordIdx == IDX_PIN_INFO) begin
            // Pin state view is read-only
            st_nxt = st_nxt;
         end else if (wordIdx == IDX_WINDOW) begin
            // High lane: no storage
            if (laneHigh) begin
               st_nxt.ioValue = st_r.ioValue;
            end else if (windowIndex == hrmg_pkg::WIN_IO_DIRECTION) begin
               st_nxt.ioDirection = mergedWord[7:0];
            end else if (windowIndex == hrmg_pkg::WIN_IO_VALUE) begin
               st_nxt.ioValue = mergedWord[7:0];
            end else begin
               st_nxt.window[windowIndex] = mergedWord[7:0];
            end
         end else if (isByteWide(wordIdx)) begin
            // Keep the upper byte clear so it reads back as zero
            st_nxt.words[wordIdx] = {8'h00, mergedWord[7:0]};
         end else begin
            st_nxt.words[wordIdx] = mergedWord;
         end
      end

      // Software reset clears only the communication side registers;
      // it wins over a host write in the same cycle so the unit restarts clean
      // Pins and storage slots
      // keep their value through
      // a soft reset.
      if (softReset) begin
         st_nxt.words[IDX_STATUS_MASK]  = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_DIAG_COMMAND] = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_EXT_COMMAND]  = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_IRQ_STATUS]   = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_IRQ_MASK]     = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_RX_FLAGS_HI]  = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_RX_FLAGS_LO]  = hrmg_pkg::RST_WORD;
         st_nxt.words[IDX_ERROR_INFO]   = hrmg_pkg::RST_WORD;
      end
   end

   // Hardware reset alone loads the full reset image
   // Hard reset is taken even
   // with the clock enable low,
   // so a frozen block comes
   // up clean.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= RST_STATE;
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state flip-flops
   // All outputs are flops;
   // none is fed by a pin
   // directly.
   assign hostRdData  = st_r.rdData;
   assign hostRdValid = st_r.rdValid;
   assign ioPinsOut   = st_r.ioValue;
   // A zero direction bit drives the pin
   assign ioPinsOe    = ~st_r.ioDirection;

endmodule // hrmg_top

// ### hrmg_pkg.sv
// Package with offsets, field positions, reset values and state types of the register map
package hrmg_pkg;

   // Width of every register word and of the byte lane
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int IO_W   = 8;

   // Byte offsets on the six-bit host address
   localparam logic [5:0] OFF_LEGACY_STATUS_MASK  = 6'h00;
   localparam logic [5:0] OFF_LEGACY_DIAG_COMMAND = 6'h02;
   localparam logic [5:0] OFF_LEGACY_REG_TWO      = 6'h04;
   localparam logic [5:0] OFF_LEGACY_REG_THREE    = 6'h06;
   localparam logic [5:0] OFF_LEGACY_REG_FOUR     = 6'h08;
   localparam logic [5:0] OFF_LEGACY_REG_FIVE     = 6'h0a;
   localparam logic [5:0] OFF_LEGACY_REG_SIX      = 6'h0c;
   localparam logic [5:0] OFF_INDEXED_WINDOW      = 6'h0e;
   localparam logic [5:0] OFF_NETWORK_TIME        = 6'h10;
   localparam logic [5:0] OFF_EXT_IRQ_STATUS      = 6'h12;
   localparam logic [5:0] OFF_EXT_IRQ_MASK        = 6'h14;
   localparam logic [5:0] OFF_EXT_COMMAND         = 6'h16;
   localparam logic [5:0] OFF_RX_SOURCE_ID        = 6'h18;
   localparam logic [5:0] OFF_TX_SOURCE_ID        = 6'h1a;
   localparam logic [5:0] OFF_RX_FLAGS_HIGH       = 6'h1c;
   localparam logic [5:0] OFF_RX_FLAGS_LOW        = 6'h1e;
   localparam logic [5:0] OFF_TIME_MASTER_ID      = 6'h20;
   localparam logic [5:0] OFF_OPERATING_MODE      = 6'h22;
   localparam logic [5:0] OFF_CARRY_FLAGS         = 6'h24;
   localparam logic [5:0] OFF_RX_MAP_HIGH         = 6'h26;
   localparam logic [5:0] OFF_RX_MAP_LOW          = 6'h28;
   localparam logic [5:0] OFF_HIGHEST_NODE_ID     = 6'h2a;
   localparam logic [5:0] OFF_OWN_NODE_ID         = 6'h2c;
   localparam logic [5:0] OFF_PACKET_SIZE_CFG     = 6'h2e;
   localparam logic [5:0] OFF_CLOCK_PRESCALE      = 6'h30;
   localparam logic [5:0] OFF_TIME_DIFFERENCE     = 6'h32;
   localparam logic [5:0] OFF_PIN_STATE_INFO      = 6'h34;
   localparam logic [5:0] OFF_UNUSED_SLOT_A       = 6'h36;
   localparam logic [5:0] OFF_UNUSED_SLOT_B       = 6'h38;
   localparam logic [5:0] OFF_ERROR_INFO          = 6'h3a;
   localparam logic [5:0] OFF_RESERVED_SLOT_A     = 6'h3c;
   localparam logic [5:0] OFF_RESERVED_SLOT_B     = 6'h3e;

   // Window index field in legacy register five, low nibble
   localparam int WIN_IDX_LSB = 0;
   localparam int WIN_IDX_W   = 4;
   // Window selections of the I/O port
   localparam logic [3:0] WIN_IO_DIRECTION = 4'hb;
   localparam logic [3:0] WIN_IO_VALUE     = 4'ha;

   // Alias enable bit in the operating mode register
   localparam int WIDE_ALIAS_BIT = 0;

   // Pin state info bits: live bus width and byte lane straps
   localparam int PIN_BUS_WIDTH_BIT   = 0;
   localparam int PIN_LANE_REVERSE_BIT = 1;

   // Hardware reset values
   localparam logic [15:0] RST_WORD         = 16'h0000;
   localparam logic [7:0]  RST_WINDOW_ENTRY = 8'h00;
   localparam logic [7:0]  RST_IO_DIRECTION = 8'hff;
   localparam logic [7:0]  RST_IO_VALUE     = 8'h00;

   // Complete state of the register map
   typedef struct packed {
      logic [31:0][15:0] words;       // One slot per word offset
      logic [15:0][7:0]  window;      // Indexed window entries
      logic [7:0]        ioDirection; // Per pin, 0 drives
      logic [7:0]        ioValue;     // Value driven on output pins
      logic [15:0]       rdData;      // Registered read answer
      logic              rdValid;     // Read answer strobe
   } hrmg_state_s;

endpackage

// ### hrmg_sync2.sv
// Two flip-flop synchroniser for pin levels entering the clock domain
`timescale 1ns/1ps
module hrmg_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // Both stages of the synchroniser in one state word
   typedef struct packed {
      logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage2
      logic [WIDTH-1:0] stage2; // Settled copy
   } hrmg_sync_s;

   hrmg_sync_s st_r;
   hrmg_sync_s st_nxt;

   // Shift the pin level through two stages
   always_comb begin
      st_nxt        = st_r;
      st_nxt.stage1 = asyncIn;
      st_nxt.stage2 = st_r.stage1;
   end

   // Register the stages, frozen while the clock enable is low
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   assign syncOut = st_r.stage2;

endmodule // hrmg_sync2

// ### hrmg_sva.sv
// Checker of the register map port behaviour, bound to the top module
`timescale 1ns/1ps
module hrmg_sva #(
   parameter int IO_WIDTH = 8
) (
   input wire logic                ref_clk,
   input wire logic                sys_rst,
   input wire logic                clkEn,
   input wire logic                softReset,
   input wire logic                busWidthSelect,
   input wire logic                byteLaneReverseN,
   input wire logic [5:0]          hostAddr,
   input wire logic [15:0]         hostWrData,
   input wire logic                hostWrEn,
   input wire logic                hostRdEn,
   input wire logic [15:0]         hostRdData,
   input wire logic                hostRdValid,
   input wire logic [IO_WIDTH-1:0] ioPinsIn,
   input wire logic [IO_WIDTH-1:0] ioPinsOut,
   input wire logic [IO_WIDTH-1:0] ioPinsOe
);
   // One clock domain; every check is muted while hard reset holds
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // A request only counts on an enabled edge
   wire logic rdTaken = hostRdEn && clkEn;
   wire logic wrTaken = hostWrEn && clkEn;

   a_answer_next: assert property (rdTaken |=> hostRdValid)
      else $error("Read answer missing one cycle after a read");
   a_answer_cause: assert property (hostRdValid |-> $past(rdTaken)
      || $past(hostRdValid && !clkEn))
      else $error("Read answer without a read request");
   a_answer_single: assert property (hostRdValid && clkEn && !hostRdEn |=> !hostRdValid)
      else $error("Read answer longer than one cycle");
   a_data_holds: assert property (!hostRdValid |-> $stable(hostRdData))
      else $error("Read data moved without a read answer");
   a_reserved_zero: assert property (rdTaken && hostAddr[5:1] inside {5'h1b, 5'h1c, 5'h1e, 5'h1f}
      |=> hostRdData == 16'h0000)
      else $error("Unused or reserved slot read nonzero");
   // Byte answers leave the upper lane clear once the width strap has been low a while
   a_byte_upper_zero: assert property (hostRdValid && !busWidthSelect && !$past(busWidthSelect, 4)
      |-> hostRdData[15:8] == 8'h00)
      else $error("Byte access answer has a nonzero upper lane");
   // The strap is seen two enabled edges late, so its history is part of the cause
   a_strap_width: assert property (rdTaken && hostAddr == 6'h34 && busWidthSelect
      && $past(busWidthSelect, 2) && !$past(sys_rst) && !$past(sys_rst, 2) && $past(clkEn)
      && $past(clkEn, 2) |=> hostRdData[0] == 1'b1)
      else $error("Pin state info does not show word access");
   // Pin drivers only move after a taken write or a hard reset
   a_io_write_only: assert property (!$past(wrTaken) && !$past(sys_rst)
      |-> $stable(ioPinsOe) && $stable(ioPinsOut))
      else $error("Pin drive changed without a write");
endmodule // hrmg_sva

bind hrmg_top hrmg_sva #(.IO_WIDTH(IO_WIDTH)) u_hrmg_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .clkEn(clkEn), .softReset(softReset), .busWidthSelect(busWidthSelect),
   .byteLaneReverseN(byteLaneReverseN), .hostAddr(hostAddr), .hostWrData(hostWrData),
   .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostRdData(hostRdData),
   .hostRdValid(hostRdValid), .ioPinsIn(ioPinsIn), .ioPinsOut(ioPinsOut), .ioPinsOe(ioPinsOe));

// ### hrmg_pin_model.sv
// Pin-side partner that resolves each two-way I/O pin level
`timescale 1ns/1ps
module hrmg_pin_model #(
   parameter int IO_WIDTH = 8
) (
   input  wire logic [IO_WIDTH-1:0] ioPinsOut,
   input  wire logic [IO_WIDTH-1:0] ioPinsOe,
   input  wire logic [IO_WIDTH-1:0] extLevel,
   output logic      [IO_WIDTH-1:0] ioPinsIn
);
   // Driven pins show the device value, input pins the outside level
   assign ioPinsIn = (ioPinsOe & ioPinsOut) | (~ioPinsOe & extLevel);
endmodule // hrmg_pin_model

// ### hrmg_tb_top.sv
// Self-checking bench of the register map: words, bytes, alias, I/O window, resets
`timescale 1ns/1ps
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, act, exp); end end
module hrmg_tb_top;
   logic        ref_clk          = 1'b0;      // Bench clock, 5 ns period
   logic        sys_rst          = 1'b1;      // Hard reset held at start
   logic        clkEn            = 1'b1;      // Lowered once to show a frozen edge
   logic        softReset        = 1'b0;
   logic        busWidthSelect   = 1'b1;      // Start in word access
   logic        byteLaneReverseN = 1'b1;      // Start without lane swap
   logic [5:0]  hostAddr         = 6'h00;
   logic [15:0] hostWrData       = 16'h0000;
   logic        hostWrEn         = 1'b0;
   logic        hostRdEn         = 1'b0;
   logic [15:0] hostRdData;
   logic        hostRdValid;
   logic [7:0]  extLevel         = 8'h00;     // Outside level on undriven pins
   logic [7:0]  ioPinsIn;
   logic [7:0]  ioPinsOut;
   logic [7:0]  ioPinsOe;
   logic [15:0] expQ[$];                      // Expected answers, oldest first
   logic [15:0] wd[32];                       // Data written per word slot
   logic [15:0] e;
   int          err_count        = 0;
   int          cmp_count        = 0;
   int          cycles           = 0;

   // Clock inverts every half period
   always #2.5 ref_clk = ~ref_clk;

   hrmg_top u_hrmg_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .softReset(softReset), .busWidthSelect(busWidthSelect),
      .byteLaneReverseN(byteLaneReverseN), .hostAddr(hostAddr), .hostWrData(hostWrData),
      .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostRdData(hostRdData),
      .hostRdValid(hostRdValid), .ioPinsIn(ioPinsIn), .ioPinsOut(ioPinsOut),
      .ioPinsOe(ioPinsOe));
   hrmg_pin_model u_hrmg_pin_model (.ioPinsOut(ioPinsOut), .ioPinsOe(ioPinsOe),
      .extLevel(extLevel), .ioPinsIn(ioPinsIn));

   // Write on the next edge; strobes stay up so calls can run back to back
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      hostAddr   <= a;
      hostWrData <= d;
      hostWrEn   <= 1'b1;
      hostRdEn   <= 1'b0;
   endtask
   // Read on the next edge and note the answer for the monitor
   task automatic rd(input logic [5:0] a, input logic [15:0] x);
      @(posedge ref_clk);
      hostAddr <= a;
      hostWrEn <= 1'b0;
      hostRdEn <= 1'b1;
      expQ.push_back(x);
   endtask
   // Drop the strobes, then wait n edges
   task automatic idle(input int n);
      @(posedge ref_clk);
      hostWrEn <= 1'b0;
      hostRdEn <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask
   // New strap levels need two enabled edges in the synchronisers
   task automatic strap(input logic w, input logic rn);
      idle(0);
      busWidthSelect   <= w;
      byteLaneReverseN <= rn;
      repeat (3) @(posedge ref_clk);
   endtask
   // Word read expected after writing d into slot a
   function automatic logic [15:0] expw(input logic [5:0] a, input logic [15:0] d);
      case (a)
         6'h34: return 16'h0003;                      // Straps: word access, no swap
         6'h36, 6'h38, 6'h3c, 6'h3e: return 16'h0000; // Unused and reserved
         6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h16, 6'h1a, 6'h20, 6'h2a,
         6'h2c, 6'h2e, 6'h30: return {8'h00, d[7:0]}; // Byte-wide registers
         default: return d;
      endcase
   endfunction
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Answers checked at mid-cycle against the oldest note; a missing note fails on x
   always @(negedge ref_clk) begin
      if (hostRdValid === 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx;
         `CHK(hostRdData, e)
      end
   end
   // Hang guard, far above the roughly 140 cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'hb0f2));
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(ioPinsOe, 8'h00)
      wr(6'h0a, 16'h000b);
      rd(6'h0e, 16'h00ff);
      // Every word slot but the window at 0e written with random data, then read back to back
      for (int i = 0; i < 32; i++) begin
         wd[i] = 16'($urandom());
         if (i != 7) wr(6'(2 * i), wd[i]);
      end
      for (int i = 0; i < 32; i++)
         if (i != 7) rd(6'(2 * i), expw(6'(2 * i), wd[i]));
      // Byte access without swap, alias off then on
      strap(1'b0, 1'b1);
      wr(6'h22, 16'h0000);
      wr(6'h10, 16'h005a);
      wr(6'h11, 16'h00a5);
      wr(6'h18, 16'h0011);
      wr(6'h19, 16'h0022);
      rd(6'h17, 16'h0000);
      rd(6'h09, 16'h0000);
      wr(6'h22, 16'h0001);
      wr(6'h08, 16'h0033);
      rd(6'h09, 16'h0033);
      wr(6'h09, 16'h0044);
      rd(6'h08, 16'h0044);
      rd(6'h11, 16'h00a5);
      // Same registers with the lanes reversed
      strap(1'b0, 1'b0);
      rd(6'h10, 16'h00a5);
      rd(6'h11, 16'h005a);
      rd(6'h18, 16'h0022);
      rd(6'h19, 16'h0011);
      rd(6'h16, 16'h0000);
      rd(6'h08, 16'h0044);
      rd(6'h37, 16'h0000);
      // I/O port: low nibble driven, high nibble from outside
      strap(1'b1, 1'b1);
      extLevel <= 8'($urandom());
      wr(6'h0a, 16'h000b);
      wr(6'h0e, 16'h00f0);
      wr(6'h0a, 16'h000a);
      wr(6'h0e, 16'h00c3);
      idle(1);
      @(negedge ref_clk);
      `CHK(ioPinsOe, 8'h0f)
      `CHK(ioPinsOut, 8'hc3)
      rd(6'h0e, {8'h00, (8'hc3 & 8'h0f) | (extLevel & 8'hf0)});
      wr(6'h0a, 16'h0003);
      wr(6'h0e, 16'h0077);
      rd(6'h0e, 16'h0077);
      wr(6'h0a, 16'h000b);
      rd(6'h0e, 16'h00f0);
      // Soft reset clears the command slot but keeps the own id slot; a write on a frozen edge is lost
      wr(6'h16, 16'h00aa);
      wr(6'h2c, 16'h0055);
      idle(0);
      softReset  <= 1'b1;
      @(posedge ref_clk);
      softReset  <= 1'b0;
      clkEn      <= 1'b0;
      hostAddr   <= 6'h2c;
      hostWrData <= 16'h0099;
      hostWrEn   <= 1'b1;
      @(posedge ref_clk);
      clkEn      <= 1'b1;
      hostWrEn   <= 1'b0;
      rd(6'h16, 16'h0000);
      rd(6'h2c, 16'h0055);
      // Second hard reset in mid-run restores the initial values
      idle(2);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(6'h2c, 16'h0000);
      idle(3);
      @(negedge ref_clk);
      `CHK(ioPinsOe, 8'h00)
      `CHK(expQ.size(), 0)
      print_verdict();
   end
endmodule // hrmg_tb_top
